//--- dvsirq_cfg.svh
// Contract
// R1 - buck a scaling done sets status bit 0
// R2 - buck b done in bit 1, bits 7:2 unused
// R3 - every voltage change raises a done event
// R4 - done bit reads 0 until done, then 1
// R5 - host writes 1 to clear any status bit
// R6 - status stays set until cleared
// R7 - unmasked set status pulls interrupt low
// R8 - masked status never pulls interrupt low
// R9 - buck done masks rw, reset to 1
// R10 - buck sense reads 1 while scaling in progress
// R11 - linreg fault status bits 0 to 2
// R12 - linreg fault masks rw, reset to 1
// R13 - linreg fault sense follows live fault
// R14 - interrupt is OR of all unmasked groups
`ifndef DVSIRQ_CFG_SVH
`define DVSIRQ_CFG_SVH

`define DVSIRQ_OFF_BUCK_STAT  8'h0e
`define DVSIRQ_OFF_BUCK_MASK  8'h0f
`define DVSIRQ_OFF_BUCK_SENSE 8'h10
`define DVSIRQ_OFF_LIN_STAT   8'h18
`define DVSIRQ_OFF_LIN_MASK   8'h19
`define DVSIRQ_OFF_LIN_SENSE  8'h1a

`define DVSIRQ_BUCK_W         2
`define DVSIRQ_LIN_W          3
`define DVSIRQ_BUCK_PAD       6'h00
`define DVSIRQ_LIN_PAD        5'h00
`define DVSIRQ_BUCK_MASK_RST  2'h3
`define DVSIRQ_LIN_MASK_RST   3'h7
`define DVSIRQ_BUCK_FLAG_RST  2'h0
`define DVSIRQ_LIN_FLAG_RST   3'h0

// input sync vector: bit 0 scl, bit 1 sda, bits 3:2 buck live, bits 6:4 linreg live
`define DVSIRQ_IN_W           7
`define DVSIRQ_IN_RST         7'h03
`define DVSIRQ_IN_SCL         0
`define DVSIRQ_IN_SDA         1
`define DVSIRQ_IN_BUCK_LO     2
`define DVSIRQ_IN_LIN_LO      4

// serial bus device address, value arbitrary
`define DVSIRQ_SLAVE_ADDR     7'h2a

`endif

//--- dvsirq_pkg.sv
`default_nettype none
package dvsirq_pkg;
    typedef enum logic [2:0] {
        DVSIRQ_ST_IDLE     = 3'h0,
        DVSIRQ_ST_RX       = 3'h1,
        DVSIRQ_ST_ACK_PEND = 3'h2,
        DVSIRQ_ST_ACK_HOLD = 3'h3,
        DVSIRQ_ST_TX       = 3'h4,
        DVSIRQ_ST_TX_ACK   = 3'h5,
        DVSIRQ_ST_TX_NEXT  = 3'h6
    } dvsirq_state_t;

    typedef enum logic [1:0] {
        DVSIRQ_KIND_ADDR = 2'h0,
        DVSIRQ_KIND_PTR  = 2'h1,
        DVSIRQ_KIND_DATA = 2'h2
    } dvsirq_kind_t;
endpackage : dvsirq_pkg
`default_nettype wire

//--- dvsirq_sync.sv
`default_nettype none
module dvsirq_sync #(
    parameter int            W       = 1,
    parameter logic [W-1:0]  RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // pins
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level_out
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic [2:0] stage_reg;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    stage_reg    <= {3{RST_VAL[i]}};
                    level_out[i] <= RST_VAL[i];
                end else if (ce) begin
                    stage_reg <= {stage_reg[1:0], async_in[i]};
                    // stage 0 is read only by stage 1; a glitch lasting one sample is dropped
                    if (stage_reg[2] == stage_reg[1]) begin
                        level_out[i] <= stage_reg[1];
                    end
                end
            end
        end
    endgenerate
endmodule : dvsirq_sync
`default_nettype wire

//--- dvsirq_flag_bank.sv
`default_nettype none
module dvsirq_flag_bank #(
    parameter int           W        = 2,
    parameter logic [W-1:0] MASK_RST = '1,
    parameter logic [W-1:0] FLAG_RST = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // events and host writes
    input  wire logic [W-1:0] event_in,
    input  wire logic         wr_status,
    input  wire logic         wr_mask,
    input  wire logic [W-1:0] wdata,
    // state
    output logic      [W-1:0] flag_reg,
    output logic      [W-1:0] mask_reg,
    output wire logic         pending
);
    wire logic [W-1:0] clr_bits;
    wire logic [W-1:0] flag_next;

    assign clr_bits  = wr_status ? wdata : '0;                           // R5
    // a new event in the clearing cycle wins, so nothing is lost
    assign flag_next = event_in | (flag_reg & ~clr_bits);                 // R6
    assign pending   = |(flag_reg & ~mask_reg);                           // R7 R8

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_reg <= FLAG_RST;
            mask_reg <= MASK_RST;                                         // R9 R12
        end else if (ce) begin
            flag_reg <= flag_next;
            if (wr_mask) begin
                mask_reg <= wdata;
            end
        end
    end
endmodule : dvsirq_flag_bank
`default_nettype wire

//--- dvsirq_top.sv
`include "dvsirq_cfg.svh"
`default_nettype none
module dvsirq_top (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    // serial control bus, open drain data
    input  wire logic scl,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_n,
    // live conditions from the regulators
    input  wire logic buck_a_scaling_live,
    input  wire logic buck_b_scaling_live,
    input  wire logic linreg_a_fault_live,
    input  wire logic linreg_b_fault_live,
    input  wire logic linreg_c_fault_live,
    // other interrupt groups, same clock
    input  wire logic other_group_irq,
    // interrupt pin
    output logic      irq_out_n
);
    import dvsirq_pkg::*;

    function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] off);
        is_reg = (addr == off);
    endfunction : is_reg

    // synchronised inputs
    wire logic [`DVSIRQ_IN_W-1:0]   raw_in;
    wire logic [`DVSIRQ_IN_W-1:0]   sync_lvl;
    wire logic                      scl_f;
    wire logic                      sda_f;
    wire logic [`DVSIRQ_BUCK_W-1:0] buck_live;
    wire logic [`DVSIRQ_LIN_W-1:0]  lin_live;

    assign raw_in = {linreg_c_fault_live, linreg_b_fault_live, linreg_a_fault_live,
                     buck_b_scaling_live, buck_a_scaling_live, sda_in, scl};

    dvsirq_sync #(
        .W       (`DVSIRQ_IN_W),
        .RST_VAL (`DVSIRQ_IN_RST)
    ) u_sync (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .async_in  (raw_in),
        .level_out (sync_lvl)
    );

    assign scl_f     = sync_lvl[`DVSIRQ_IN_SCL];
    assign sda_f     = sync_lvl[`DVSIRQ_IN_SDA];
    assign buck_live = sync_lvl[`DVSIRQ_IN_BUCK_LO +: `DVSIRQ_BUCK_W];          // R10
    assign lin_live  = sync_lvl[`DVSIRQ_IN_LIN_LO +: `DVSIRQ_LIN_W];           // R13

    // edge history
    logic                      scl_prev_reg;
    logic                      sda_prev_reg;
    logic [`DVSIRQ_BUCK_W-1:0] buck_prev_reg;
    logic [`DVSIRQ_LIN_W-1:0]  lin_prev_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_prev_reg  <= 1'b1;
            sda_prev_reg  <= 1'b1;
            buck_prev_reg <= '0;
            lin_prev_reg  <= '0;
        end else if (ce) begin
            scl_prev_reg  <= scl_f;
            sda_prev_reg  <= sda_f;
            buck_prev_reg <= buck_live;
            lin_prev_reg  <= lin_live;
        end
    end

    // scaling finishing is the end of the in-progress level, whatever started it:
    // a host write or a power-state move both show up as one scaling window
    wire logic [`DVSIRQ_BUCK_W-1:0] buck_done_ev;
    wire logic [`DVSIRQ_LIN_W-1:0]  lin_fault_ev;

    assign buck_done_ev = buck_prev_reg & ~buck_live;                         // R1 R2 R3 R4
    assign lin_fault_ev = ~lin_prev_reg & lin_live;                           // R11

    // bus conditions
    wire logic scl_rise;
    wire logic scl_fall;
    wire logic start_det;
    wire logic stop_det;

    assign scl_rise  = scl_f & ~scl_prev_reg;
    assign scl_fall  = ~scl_f & scl_prev_reg;
    assign start_det = scl_f & scl_prev_reg & sda_prev_reg & ~sda_f;
    assign stop_det  = scl_f & scl_prev_reg & ~sda_prev_reg & sda_f;

    // bus engine state
    dvsirq_state_t state_reg;
    dvsirq_state_t state_next;
    dvsirq_kind_t  kind_reg;
    dvsirq_kind_t  kind_next;
    logic [2:0]    bit_reg;
    logic [2:0]    bit_next;
    logic [7:0]    shift_reg;
    logic [7:0]    shift_next;
    logic [7:0]    ptr_reg;
    logic [7:0]    ptr_next;
    logic          rw_reg;
    logic          rw_next;
    logic          oe_n_next;
    logic          wr_fire;

    // register file
    wire logic [`DVSIRQ_BUCK_W-1:0] buck_flag;
    wire logic [`DVSIRQ_BUCK_W-1:0] buck_mask;
    wire logic [`DVSIRQ_LIN_W-1:0]  lin_flag;
    wire logic [`DVSIRQ_LIN_W-1:0]  lin_mask;
    wire logic                      buck_pending;
    wire logic                      lin_pending;
    wire logic                      wr_buck_stat;
    wire logic                      wr_buck_mask;
    wire logic                      wr_lin_stat;
    wire logic                      wr_lin_mask;
    wire logic [7:0]                rd_byte;

    assign wr_buck_stat = wr_fire & is_reg(ptr_reg, `DVSIRQ_OFF_BUCK_STAT);
    assign wr_buck_mask = wr_fire & is_reg(ptr_reg, `DVSIRQ_OFF_BUCK_MASK);
    assign wr_lin_stat  = wr_fire & is_reg(ptr_reg, `DVSIRQ_OFF_LIN_STAT);
    assign wr_lin_mask  = wr_fire & is_reg(ptr_reg, `DVSIRQ_OFF_LIN_MASK);

    dvsirq_flag_bank #(
        .W        (`DVSIRQ_BUCK_W),
        .MASK_RST (`DVSIRQ_BUCK_MASK_RST),
        .FLAG_RST (`DVSIRQ_BUCK_FLAG_RST)
    ) u_buck_bank (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .event_in  (buck_done_ev),
        .wr_status (wr_buck_stat),
        .wr_mask   (wr_buck_mask),
        .wdata     (shift_reg[`DVSIRQ_BUCK_W-1:0]),
        .flag_reg  (buck_flag),
        .mask_reg  (buck_mask),
        .pending   (buck_pending)
    );

    dvsirq_flag_bank #(
        .W        (`DVSIRQ_LIN_W),
        .MASK_RST (`DVSIRQ_LIN_MASK_RST),
        .FLAG_RST (`DVSIRQ_LIN_FLAG_RST)
    ) u_lin_bank (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .event_in  (lin_fault_ev),
        .wr_status (wr_lin_stat),
        .wr_mask   (wr_lin_mask),
        .wdata     (shift_reg[`DVSIRQ_LIN_W-1:0]),
        .flag_reg  (lin_flag),
        .mask_reg  (lin_mask),
        .pending   (lin_pending)
    );

    // reads have no side effect; unused bits and unmapped offsets read zero
    assign rd_byte =
        is_reg(ptr_reg, `DVSIRQ_OFF_BUCK_STAT)  ? {`DVSIRQ_BUCK_PAD, buck_flag} :  // R2 R4
        is_reg(ptr_reg, `DVSIRQ_OFF_BUCK_MASK)  ? {`DVSIRQ_BUCK_PAD, buck_mask} :  // R9
        is_reg(ptr_reg, `DVSIRQ_OFF_BUCK_SENSE) ? {`DVSIRQ_BUCK_PAD, buck_live} :  // R10
        is_reg(ptr_reg, `DVSIRQ_OFF_LIN_STAT)   ? {`DVSIRQ_LIN_PAD, lin_flag}   :  // R11
        is_reg(ptr_reg, `DVSIRQ_OFF_LIN_MASK)   ? {`DVSIRQ_LIN_PAD, lin_mask}   :  // R12
        is_reg(ptr_reg, `DVSIRQ_OFF_LIN_SENSE)  ? {`DVSIRQ_LIN_PAD, lin_live}   :  // R13
        8'h00;

    // bus engine: bits sampled on scl rise, our drive changes only on scl fall
    always_comb begin
        state_next = state_reg;
        kind_next  = kind_reg;
        bit_next   = bit_reg;
        shift_next = shift_reg;
        ptr_next   = ptr_reg;
        rw_next    = rw_reg;
        oe_n_next  = sda_oe_n;
        wr_fire    = 1'b0;
        if (stop_det) begin
            state_next = DVSIRQ_ST_IDLE;
            oe_n_next  = 1'b1;
        end else if (start_det) begin
            state_next = DVSIRQ_ST_RX;
            kind_next  = DVSIRQ_KIND_ADDR;
            bit_next   = 3'h0;
            oe_n_next  = 1'b1;
        end else begin
            case (state_reg)
                DVSIRQ_ST_IDLE: begin
                    oe_n_next = 1'b1;
                end
                DVSIRQ_ST_RX: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_f};
                        bit_next   = bit_reg + 3'h1;
                        if (bit_reg == 3'h7) begin
                            state_next = DVSIRQ_ST_ACK_PEND;
                        end
                    end
                end
                DVSIRQ_ST_ACK_PEND: begin
                    if (scl_fall) begin
                        if (kind_reg == DVSIRQ_KIND_ADDR &&
                            shift_reg[7:1] != `DVSIRQ_SLAVE_ADDR) begin
                            state_next = DVSIRQ_ST_IDLE;
                        end else begin
                            oe_n_next  = 1'b0;
                            state_next = DVSIRQ_ST_ACK_HOLD;
                            if (kind_reg == DVSIRQ_KIND_ADDR) begin
                                rw_next = shift_reg[0];
                            end else if (kind_reg == DVSIRQ_KIND_PTR) begin
                                ptr_next = shift_reg;
                            end else begin
                                wr_fire  = 1'b1;                                     // R5
                                ptr_next = ptr_reg + 8'h01;
                            end
                        end
                    end
                end
                DVSIRQ_ST_ACK_HOLD: begin
                    if (scl_fall) begin
                        bit_next = 3'h0;
                        if (kind_reg == DVSIRQ_KIND_ADDR && rw_reg) begin
                            shift_next = rd_byte;
                            oe_n_next  = rd_byte[7];
                            ptr_next   = ptr_reg + 8'h01;
                            state_next = DVSIRQ_ST_TX;
                        end else begin
                            oe_n_next  = 1'b1;
                            state_next = DVSIRQ_ST_RX;
                            kind_next  = (kind_reg == DVSIRQ_KIND_ADDR) ? DVSIRQ_KIND_PTR
                                                                         : DVSIRQ_KIND_DATA;
                        end
                    end
                end
                DVSIRQ_ST_TX: begin
                    if (scl_rise) begin
                        bit_next = bit_reg + 3'h1;
                        if (bit_reg == 3'h7) begin
                            state_next = DVSIRQ_ST_TX_ACK;
                        end
                    end else if (scl_fall) begin
                        oe_n_next  = shift_reg[6];
                        shift_next = {shift_reg[6:0], 1'b0};
                    end
                end
                DVSIRQ_ST_TX_ACK: begin
                    if (scl_fall) begin
                        oe_n_next = 1'b1;
                    end else if (scl_rise) begin
                        state_next = sda_f ? DVSIRQ_ST_IDLE : DVSIRQ_ST_TX_NEXT;
                    end
                end
                DVSIRQ_ST_TX_NEXT: begin
                    if (scl_fall) begin
                        shift_next = rd_byte;
                        oe_n_next  = rd_byte[7];
                        ptr_next   = ptr_reg + 8'h01;
                        bit_next   = 3'h0;
                        state_next = DVSIRQ_ST_TX;
                    end
                end
                default: begin
                    state_next = DVSIRQ_ST_IDLE;
                    oe_n_next  = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= DVSIRQ_ST_IDLE;
            kind_reg  <= DVSIRQ_KIND_ADDR;
            bit_reg   <= 3'h0;
            shift_reg <= 8'h00;
            ptr_reg   <= 8'h00;
            rw_reg    <= 1'b0;
            sda_oe_n  <= 1'b1;
        end else if (ce) begin
            state_reg <= state_next;
            kind_reg  <= kind_next;
            bit_reg   <= bit_next;
            shift_reg <= shift_next;
            ptr_reg   <= ptr_next;
            rw_reg    <= rw_next;
            sda_oe_n  <= oe_n_next;
        end
    end

    // open drain: the data level is always low, the enable alone decides the wire
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sda_out   <= 1'b0;
            irq_out_n <= 1'b1;
        end else if (ce) begin
            sda_out   <= 1'b0;
            irq_out_n <= ~(buck_pending | lin_pending | other_group_irq);           // R7 R8 R14
        end
    end
endmodule : dvsirq_top
`default_nettype wire

//--- dvsirq_host.sv
`include "dvsirq_cfg.svh"
`default_nettype none
module dvsirq_host (
    // clock
    input  wire logic clk,
    // bus pins, data is open drain with a pull-up
    input  wire logic sda,
    output var logic  scl,
    output var logic  sda_drv
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w

    // 12 clk low and 10 clk high keep every phase above the 8 clk minimum
    task automatic bit_x(input logic b, output logic r);
        w(2);
        sda_drv = b;
        w(10);
        scl = 1'b1;
        w(10);
        r = sda;
        scl = 1'b0;
    endtask : bit_x

    task automatic start;
        w(2);
        sda_drv = 1'b1;
        w(10);
        scl = 1'b1;
        w(10);
        sda_drv = 1'b0;
        w(10);
        scl = 1'b0;
    endtask : start

    task automatic stop;
        w(2);
        sda_drv = 1'b0;
        w(10);
        scl = 1'b1;
        w(10);
        sda_drv = 1'b1;
        w(10);
    endtask : stop

    task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
                         output logic nine);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            q[i] = r;
        end
        bit_x(last, nine);
    endtask : xbyte

    // ok is high only when every byte was acknowledged
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                      output logic ok);
        logic [7:0] q;
        logic       n0;
        logic       n1;
        logic       n2;
        start();
        xbyte({a, 1'b0}, 1'b1, q, n0);
        xbyte(p, 1'b1, q, n1);
        xbyte(d, 1'b1, q, n2);
        stop();
        ok = !(n0 | n1 | n2);
    endtask : wr

    // single byte read ends with a nack so the device goes idle
    task automatic rd(input logic [7:0] p, output logic [7:0] q);
        logic [7:0] t;
        logic       n;
        start();
        xbyte({`DVSIRQ_SLAVE_ADDR, 1'b0}, 1'b1, t, n);
        xbyte(p, 1'b1, t, n);
        start();
        xbyte({`DVSIRQ_SLAVE_ADDR, 1'b1}, 1'b1, t, n);
        xbyte(8'hff, 1'b1, q, n);
        stop();
    endtask : rd
endmodule : dvsirq_host
`default_nettype wire

//--- dvsirq_chk.sv
`default_nettype none
module dvsirq_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // bus
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    // live inputs and interrupt
    input wire logic buck_a_scaling_live,
    input wire logic buck_b_scaling_live,
    input wire logic linreg_a_fault_live,
    input wire logic linreg_b_fault_live,
    input wire logic linreg_c_fault_live,
    input wire logic other_group_irq,
    input wire logic irq_out_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // scl high this long means no transfer can be under way
    localparam int QUIET = 40;
    logic [6:0] hi_cnt_reg;
    logic       touched_reg;
    wire        quiet = hi_cnt_reg >= 7'(QUIET);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hi_cnt_reg <= 7'h00;
            touched_reg <= 1'b0;
        end else if (!scl) begin
            hi_cnt_reg <= 7'h00;
            touched_reg <= 1'b1;
        end else if (hi_cnt_reg != 7'h7f) begin
            hi_cnt_reg <= hi_cnt_reg + 7'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_raise;
        ce && other_group_irq;
    endsequence
    sequence s_quiet_rise;
        quiet && $rose(irq_out_n);
    endsequence

    AST_RST_VAL: assert property (disable iff (1'b0) rst |=> irq_out_n && sda_oe_n)
        else $error("reset state wrong");
    AST_OTHER_IRQ: assert property (s_raise |=> !irq_out_n)
        else $error("other group did not pull irq");
    AST_MASK_RST: assert property (!touched_reg && !$past(other_group_irq) |-> irq_out_n)
        else $error("irq low with reset masks");
    AST_IRQ_STICKY: assert property (s_quiet_rise |-> $past(other_group_irq, 2))
        else $error("irq released without host clear");
    AST_SDA_OD: assert property (!sda_out)
        else $error("sda driven high");
    AST_ACK_LOW_SCL: assert property ($fell(sda_oe_n) |-> !scl)
        else $error("sda pulled while scl high");
    AST_SDA_IDLE: assert property (quiet |-> sda_oe_n)
        else $error("sda held on idle bus");
    AST_CE_FREEZE: assert property (!ce |=> $stable(irq_out_n) && $stable(sda_oe_n))
        else $error("outputs moved with ce low");
    COV_IRQ: cover property ($fell(irq_out_n));
endmodule : dvsirq_chk

bind dvsirq_top dvsirq_chk chk (
    .clk(clk), .rst(rst), .ce(ce), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .buck_a_scaling_live(buck_a_scaling_live),
    .buck_b_scaling_live(buck_b_scaling_live), .linreg_a_fault_live(linreg_a_fault_live),
    .linreg_b_fault_live(linreg_b_fault_live), .linreg_c_fault_live(linreg_c_fault_live),
    .other_group_irq(other_group_irq), .irq_out_n(irq_out_n)
);
`default_nettype wire

//--- tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       ce = 1'b1;
    logic [4:0] live = 5'h00;
    logic       other = 1'b0;
    int         err_count = 0;
    int         checks_done = 0;
    wire        scl;
    wire        sda_drv;
    wire        sda_out;
    wire        sda_oe_n;
    wire        irq_out_n;
    // pull-up: the line is low if either side pulls it
    wire        sda = sda_drv & (sda_oe_n | sda_out);

    always #25 clk = ~clk;

    dvsirq_top dut (
        .clk(clk), .rst(rst), .ce(ce), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .buck_a_scaling_live(live[0]), .buck_b_scaling_live(live[1]),
        .linreg_a_fault_live(live[2]), .linreg_b_fault_live(live[3]),
        .linreg_c_fault_live(live[4]), .other_group_irq(other), .irq_out_n(irq_out_n)
    );
    dvsirq_host host (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] p, input logic [7:0] e);
        logic [7:0] q;
        host.rd(p, q);
        chk(q, e);
    endtask : rchk

    task automatic wchk(input logic [7:0] p, input logic [7:0] d);
        logic ok;
        host.wr(7'h2a, p, d, ok);
        chk({7'h00, ok}, 8'h01);
    endtask : wchk

    task automatic ichk(input logic e);
        repeat (3) @(negedge clk);
        chk({7'h00, irq_out_n}, {7'h00, e});
    endtask : ichk

    // ten clk covers the input filter and the flag update
    task automatic set_live(input logic [4:0] v);
        @(negedge clk);
        live = v;
        repeat (10) @(negedge clk);
    endtask : set_live

    task automatic t_reset;
        set_live(5'h1c);
        set_live(5'h00);
        ichk(1'b1);
        rchk(8'h0e, 8'h00);
        rchk(8'h0f, 8'h03);
        rchk(8'h10, 8'h00);
        rchk(8'h18, 8'h07);
        rchk(8'h19, 8'h07);
        rchk(8'h1a, 8'h00);
        rchk(8'h11, 8'h00);
        wchk(8'h18, 8'h07);
    endtask : t_reset

    task automatic t_refuse;
        logic ok;
        host.wr(7'h2b, 8'h0f, 8'h00, ok);
        chk({7'h00, ok}, 8'h00);
        rchk(8'h0f, 8'h03);
        wchk(8'h10, 8'hff);
        rchk(8'h10, 8'h00);
    endtask : t_refuse

    task automatic t_buck;
        set_live(5'h01);
        rchk(8'h10, 8'h01);
        rchk(8'h0e, 8'h00);
        set_live(5'h00);
        rchk(8'h0e, 8'h01);
        ichk(1'b1);
        wchk(8'h0f, 8'h02);
        ichk(1'b0);
        wchk(8'h0e, 8'h02);
        rchk(8'h0e, 8'h01);
        wchk(8'h0e, 8'h01);
        rchk(8'h0e, 8'h00);
        ichk(1'b1);
        set_live(5'h02);
        rchk(8'h10, 8'h02);
        set_live(5'h00);
        wchk(8'h0e, 8'hff);
        set_live(5'h02);
        set_live(5'h00);
        rchk(8'h0e, 8'h02);
        ichk(1'b1);
        wchk(8'h0e, 8'hff);
        wchk(8'h0f, 8'h03);
    endtask : t_buck

    task automatic t_lin;
        wchk(8'h19, 8'h00);
        rchk(8'h19, 8'h00);
        for (int i = 0; i < 3; i++) begin
            set_live(5'h04 << i);
            set_live(5'h00);
            rchk(8'h18, 8'h01 << i);
            wchk(8'h18, 8'h01 << i);
        end
        set_live(5'h1c);
        rchk(8'h1a, 8'h07);
        set_live(5'h00);
        rchk(8'h1a, 8'h00);
        rchk(8'h18, 8'h07);
        ichk(1'b0);
        @(negedge clk);
        other = 1'b1;
        wchk(8'h18, 8'h07);
        ichk(1'b0);
        other = 1'b0;
        ichk(1'b1);
        wchk(8'h19, 8'hff);
        rchk(8'h19, 8'h07);
    endtask : t_lin

    task automatic t_ce;
        @(negedge clk);
        ce = 1'b0;
        other = 1'b1;
        ichk(1'b1);
        ce = 1'b1;
        ichk(1'b0);
        // let the bus go quiet first, so the sticky check sees this release
        repeat (40) @(negedge clk);
        other = 1'b0;
        ichk(1'b1);
    endtask : t_ce

    task automatic conclude;
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (5) @(negedge clk);
        t_reset();
        t_refuse();
        t_buck();
        t_lin();
        t_ce();
        conclude();
    end

    // about 40 transfers of at most 1200 clk each fit well inside this span
    initial begin
        #4_000_000;
        err_count++;
        conclude();
    end
endmodule : tb_top
`default_nettype wire
